// File: mcuic_cfg.svh
// Offsets, field positions, vectors and reset values of the interrupt controller
`ifndef MCUIC_CFG_SVH
`define MCUIC_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
// Printed offset is a register index; byte address is four times it
`define MCUIC_IRQ_REG_INDEX 8'h0b
`define MCUIC_IRQ_REG_ADDR 8'h2c
`define MCUIC_IRQ_REG_RESET 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCUIC_BIT_MASTER_EN 0
`define MCUIC_BIT_EXT_EN 1
`define MCUIC_BIT_T0_EN 2
`define MCUIC_BIT_T1_EN 3
`define MCUIC_BIT_EXT_FLAG 4
`define MCUIC_BIT_T0_FLAG 5
`define MCUIC_BIT_T1_FLAG 6
`define MCUIC_BIT_UNUSED 7

// ----------------------------------------
// Vectors and stack
// ----------------------------------------
`define MCUIC_VEC_EXT 12'h004
`define MCUIC_VEC_T0 12'h008
`define MCUIC_VEC_T1 12'h00c
`define MCUIC_STACK_LEVELS 4

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define MCUIC_RESP_OKAY 2'h0
`define MCUIC_RESP_DECERR 2'h3

`endif

// File: mcuic_pkg.sv
// Types shared by the interrupt controller and its users
package mcuic_pkg;

    // ----------------------------------------
    // Call handed to the core sequencer
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic push_pc;
        logic [11:0] vector;
    } mcuic_call_t;

    // ----------------------------------------
    // Source selection, one-hot
    // ----------------------------------------
    typedef enum logic [2:0] {
        MCUIC_SEL_EXT = 3'h1,
        MCUIC_SEL_T0 = 3'h2,
        MCUIC_SEL_T1 = 3'h4
    } mcuic_src_t;

    // ----------------------------------------
    // Bus write channel state
    // ----------------------------------------
    typedef enum logic [1:0] {
        MCUIC_WR_IDLE = 2'h1,
        MCUIC_WR_RESP = 2'h2
    } mcuic_wr_state_t;

endpackage

// File: mcuic_irq_ctrl.sv
// Interrupt control unit: request flags, masking, priority and vectored call
//
// Summary of operation
// - Falling edge on external pin sets external flag, bit 4.
// - Pending enabled external request, stack not full: call 04H, clear flag and master.
// - Timer 0 overflow sets timer 0 flag, bit 5.
// - Pending enabled timer 0 request, stack not full: call 08H, clear flag and master.
// - Timer 1 behaves like timer 0, enable bit 3, flag bit 6.
// - With master enable clear, requests only set flags, no acknowledge.
// - Software re-enabling master and source enable permits nested acknowledge.
// - Full stack withholds acknowledge until a return pops it.
// - Acknowledge pushes only the program counter, nothing else.
// - Return-and-reenable sets master enable; plain return leaves it.
// - Requests are serviced at the next second-phase pulse.
// - Simultaneous requests: external first, then timer 0, then timer 1.
// - Bit 0 master, 1 external, 2 timer 0, 3 timer 1 enable; one enables.
// - Service needs master and source enable; disabled requests stay pending.
// - Flags stay set until acknowledged or cleared by software.
// - Bit 7 is unimplemented and reads zero.
// - Register sits at index 0BH, reached by ordinary reads and writes.
// - Any pending source wakes the core from halt.
// - Return stack has four levels; full when all four are used.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "mcuic_cfg.svh"

module mcuic_irq_ctrl
    import mcuic_pkg::*;
#(
    parameter int STACK_LEVELS = `MCUIC_STACK_LEVELS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt sources
    input wire logic i_ext_irq_n,
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    // Core sequencer and stack
    input wire logic i_second_phase_pulse,
    input wire logic [2:0] i_stack_index,
    input wire logic i_return_and_reenable_instr,
    input wire logic i_plain_return_instr,
    output mcuic_call_t o_call,
    output logic o_wake
);

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic master_irq_enable;
    logic external_irq_enable;
    logic timer0_irq_enable;
    logic timer1_irq_enable;
    logic external_irq_flag;
    logic timer0_irq_flag;
    logic timer1_irq_flag;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [7:0] w_data;
    logic w_byte0;
    logic w_held;
    mcuic_wr_state_t wr_state;
    mcuic_call_t next_call;

    // ----------------------------------------
    // Source detection
    // ----------------------------------------
    // pin synchroniser
    // Resets to the idle pin level so that release gives no false edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
        end else begin
            ext_meta <= i_ext_irq_n;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    wire ext_fall = ext_prev & ~ext_sync;
    wire t0_event = i_timer0_ovf;
    wire t1_event = i_timer1_ovf;

    // ----------------------------------------
    // Masking and priority
    // ----------------------------------------
    // four-level stack full test
    wire stack_full = (i_stack_index >= 3'(STACK_LEVELS));
    wire ext_ready = external_irq_flag & external_irq_enable;
    wire t0_ready = timer0_irq_flag & timer0_irq_enable;
    wire t1_ready = timer1_irq_flag & timer1_irq_enable;
    // master and source enable set again permit nesting
    // master enable blocks, full stack withholds
    wire ack_allowed = master_irq_enable & ~stack_full;
    // service only at the phase pulse
    wire ack_now = i_second_phase_pulse & ack_allowed & (ext_ready | t0_ready | t1_ready);
    wire [2:0] sel = ext_ready ? MCUIC_SEL_EXT : (t0_ready ? MCUIC_SEL_T0 : MCUIC_SEL_T1);
    wire ack_ext = ack_now & sel[0];
    wire ack_t0 = ack_now & sel[1];
    wire ack_t1 = ack_now & sel[2];
    wire [11:0] sel_vector = ack_ext ? `MCUIC_VEC_EXT : (ack_t0 ? `MCUIC_VEC_T0 : `MCUIC_VEC_T1);

    // only the program counter is pushed
    always_comb begin
        next_call.valid = ack_now;
        next_call.push_pc = ack_now;
        next_call.vector = ack_now ? sel_vector : 12'h000;
    end

    // ----------------------------------------
    // Bus write channel
    // ----------------------------------------
    // Address and data may arrive in either order; each is held until both are here
    assign s_axi_awready = ~aw_held & (wr_state == MCUIC_WR_IDLE);
    assign s_axi_wready = ~w_held & (wr_state == MCUIC_WR_IDLE);
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_fire = aw_held & w_held & (wr_state == MCUIC_WR_IDLE);
    wire wr_hit = (aw_addr == `MCUIC_IRQ_REG_ADDR);
    wire sw_we = wr_fire & wr_hit & w_byte0;
    assign s_axi_bvalid = (wr_state == MCUIC_WR_RESP);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 8'h00;
            w_byte0 <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_byte0 <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_state <= MCUIC_WR_IDLE;
            s_axi_bresp <= `MCUIC_RESP_OKAY;
        end else begin
            unique case (wr_state)
                MCUIC_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state <= MCUIC_WR_RESP;
                        s_axi_bresp <= wr_hit ? `MCUIC_RESP_OKAY : `MCUIC_RESP_DECERR;
                    end
                end
                MCUIC_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state <= MCUIC_WR_IDLE;
                    end
                end
                default: wr_state <= MCUIC_WR_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // enable fields, software writable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            external_irq_enable <= 1'b0;
            timer0_irq_enable <= 1'b0;
            timer1_irq_enable <= 1'b0;
        end else if (sw_we) begin
            external_irq_enable <= w_data[`MCUIC_BIT_EXT_EN];
            timer0_irq_enable <= w_data[`MCUIC_BIT_T0_EN];
            timer1_irq_enable <= w_data[`MCUIC_BIT_T1_EN];
        end
    end

    // return-and-reenable sets master; acknowledge clears it last
    // The plain return is accepted but deliberately has no effect here
    wire me_sw = sw_we ? w_data[`MCUIC_BIT_MASTER_EN] : master_irq_enable;
    wire me_ret = i_return_and_reenable_instr ? 1'b1 : me_sw;
    wire next_master = ack_now ? 1'b0 : me_ret;

    // flags hold until acknowledge or software clear
    wire next_ext_flag = ext_fall |
        (~ack_ext & (sw_we ? w_data[`MCUIC_BIT_EXT_FLAG] : external_irq_flag));
    wire next_t0_flag = t0_event |
        (~ack_t0 & (sw_we ? w_data[`MCUIC_BIT_T0_FLAG] : timer0_irq_flag));
    wire next_t1_flag = t1_event |
        (~ack_t1 & (sw_we ? w_data[`MCUIC_BIT_T1_FLAG] : timer1_irq_flag));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            master_irq_enable <= 1'b0;
            external_irq_flag <= 1'b0;
            timer0_irq_flag <= 1'b0;
            timer1_irq_flag <= 1'b0;
            o_call <= '0;
        end else begin
            master_irq_enable <= next_master;
            external_irq_flag <= next_ext_flag;
            timer0_irq_flag <= next_t0_flag;
            timer1_irq_flag <= next_t1_flag;
            o_call <= next_call;
        end
    end

    wire [7:0] irq_enable_and_flags = {1'b0, timer1_irq_flag, timer0_irq_flag,
        external_irq_flag, timer1_irq_enable, timer0_irq_enable, external_irq_enable,
        master_irq_enable};

    // any pending source wakes the core, enabled or not
    assign o_wake = external_irq_flag | timer0_irq_flag | timer1_irq_flag;

    // ----------------------------------------
    // Bus read channel
    // ----------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_hit = (s_axi_araddr == `MCUIC_IRQ_REG_ADDR);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MCUIC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? {24'h00_0000, irq_enable_and_flags} : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? `MCUIC_RESP_OKAY : `MCUIC_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence ack_seq(ready_flag);
        i_second_phase_pulse && master_irq_enable && !stack_full && ready_flag;
    endsequence

    sequence call_seq(logic [11:0] vec);
        o_call.valid && o_call.push_pc && o_call.vector == vec && !master_irq_enable;
    endsequence

    ext_edge_set_a: assert property ($fell(ext_sync) |=> external_irq_flag)
        else $error("external falling edge did not set the flag");
    ext_vector_a: assert property (ack_seq(ext_ready) |=> call_seq(`MCUIC_VEC_EXT))
        else $error("external acknowledge wrong vector or master left set");
    t0_vector_a: assert property (ack_seq(t0_ready && !ext_ready) |=>
            call_seq(`MCUIC_VEC_T0))
        else $error("timer 0 acknowledge wrong vector");
    t1_vector_a: assert property (ack_seq(t1_ready && !ext_ready && !t0_ready) |=>
            call_seq(`MCUIC_VEC_T1))
        else $error("timer 1 acknowledge wrong vector or priority");
    t1_flag_set_a: assert property (i_timer1_ovf |=> timer1_irq_flag)
        else $error("timer 1 overflow lost");
    master_block_a: assert property (!master_irq_enable |=> !o_call.valid)
        else $error("call issued with master enable clear");
    full_stack_a: assert property (stack_full |=> !o_call.valid)
        else $error("call issued while stack full");
    phase_only_a: assert property (!i_second_phase_pulse |=> !o_call.valid)
        else $error("call issued outside the phase pulse");
    reenable_a: assert property (i_return_and_reenable_instr && !ack_now |=>
            master_irq_enable)
        else $error("return did not re-enable master");
    flag_hold_a: assert property (timer0_irq_flag && !ack_t0 && !sw_we |=>
            timer0_irq_flag ##1 (timer0_irq_flag || o_call.valid || $past(sw_we)))
        else $error("timer 0 flag dropped without cause");
    hw_wins_a: assert property (sw_we && i_timer0_ovf |=> timer0_irq_flag)
        else $error("software write beat hardware set");
    bit7_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
        else $error("unimplemented bits read nonzero");
    wake_a: assert property (o_wake == (|irq_enable_and_flags[6:4]))
        else $error("wake does not follow pending flags");

    // ----------------------------------------
    // Handshake and clear checks
    // ----------------------------------------
    // Answers stand until taken; clears yield to a same-cycle set
    sequence b_wait_seq;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    sequence r_wait_seq;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    b_stands_a: assert property (b_wait_seq |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    r_stands_a: assert property (r_wait_seq |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    call_pulse_a: assert property (o_call.valid |=> !o_call.valid)
        else $error("call stood longer than one cycle");
    push_only_a: assert property (o_call.valid |-> o_call.push_pc)
        else $error("call without program counter push");
    call_idle_a: assert property (!o_call.valid |-> o_call == '0)
        else $error("idle call bus not zero");
    ext_clear_a: assert property (ack_ext && !ext_fall |=> !external_irq_flag)
        else $error("external flag not cleared by acknowledge");
    t0_clear_a: assert property (ack_t0 && !t0_event |=> !timer0_irq_flag)
        else $error("timer 0 flag not cleared by acknowledge");
    t1_clear_a: assert property (ack_t1 && !t1_event |=> !timer1_irq_flag)
        else $error("timer 1 flag not cleared by acknowledge");
    t0_flag_set_a: assert property (i_timer0_ovf |=> timer0_irq_flag)
        else $error("timer 0 overflow lost");
    t0_ack_set_a: assert property (ack_t0 && t0_event |=> timer0_irq_flag)
        else $error("new timer 0 event lost at acknowledge");
    one_set_a: assert property (ext_fall |=> !ext_fall)
        else $error("one pin edge detected twice");
    ext_hw_wins_a: assert property (sw_we && ext_fall |=> external_irq_flag)
        else $error("software write beat external edge");
    t1_hw_wins_a: assert property (sw_we && i_timer1_ovf |=> timer1_irq_flag)
        else $error("software write beat timer 1 set");
    plain_ret_a: assert property (i_plain_return_instr && !i_return_and_reenable_instr
            && !sw_we && !ack_now |=> $stable(master_irq_enable))
        else $error("plain return changed master enable");
    ext_block_a: assert property (!external_irq_enable |=>
            o_call.vector != `MCUIC_VEC_EXT)
        else $error("disabled external request serviced");
    t0_block_a: assert property (!timer0_irq_enable |=>
            o_call.vector != `MCUIC_VEC_T0)
        else $error("disabled timer 0 request serviced");
    t1_block_a: assert property (!timer1_irq_enable |=>
            o_call.vector != `MCUIC_VEC_T1)
        else $error("disabled timer 1 request serviced");

endmodule

// File: mcuic_core_model.sv
// Core sequencer and return-stack stand-in facing the interrupt controller
module mcuic_core_model
    import mcuic_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Controller call and core events
    input wire mcuic_call_t i_call,
    input wire logic i_push,
    input wire logic i_ret,
    // Sequencer outputs
    output logic o_phase,
    output logic [2:0] o_stack_index
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] div;

    assign o_phase = (div == 2'h3);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div <= 2'h0;
            o_stack_index <= 3'h0;
        end else begin
            div <= div + 2'h1;
            if ((i_call.valid || i_push) && o_stack_index < 3'h4) begin
                o_stack_index <= o_stack_index + 3'h1;
            end else if (i_ret && o_stack_index != 3'h0) begin
                o_stack_index <= o_stack_index - 3'h1;
            end
        end
    end
endmodule

// File: test_mcu_interrupt_controller.sv
// Self-checking bench of the interrupt controller against a register-level model
`include "mcuic_cfg.svh"

module test_mcu_interrupt_controller
    import mcuic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, wake, phase;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] sidx;
    // Pulses: timer 0, timer 1, reenable return, plain return, core push
    logic [4:0] pul = 5'h00;
    logic pin_n = 1'b1;
    mcuic_call_t call;
    logic [12:0] calls[$];
    int bad_count = 0;
    int n_checks = 0;
    int mreg = 0;
    int eff[5] = '{32'h20, 32'h40, 32'h1, 0, 0};
    logic [31:0] seed = 32'd90390;

    mcuic_irq_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .i_ext_irq_n(pin_n), .i_timer0_ovf(pul[0]),
        .i_timer1_ovf(pul[1]), .i_second_phase_pulse(phase), .i_stack_index(sidx),
        .i_return_and_reenable_instr(pul[2]), .i_plain_return_instr(pul[3]),
        .o_call(call), .o_wake(wake));

    mcuic_core_model mdl_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_call(call),
        .i_push(pul[4]), .i_ret(pul[2] | pul[3]), .o_phase(phase), .o_stack_index(sidx));

    initial begin
        forever #4 i_clk = ~i_clk;
    end

    // Calls last one cycle, so they are caught here and checked later
    always @(posedge i_clk) begin
        if (call.valid === 1'b1) calls.push_back({call.push_pc, call.vector});
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge i_clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge i_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
        if (er == `MCUIC_RESP_OKAY) mreg = d & 8'h7f;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge i_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge i_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(rresp, er);
    endtask

    // Register readback and wake level against the model
    task automatic look();
        rd(`MCUIC_IRQ_REG_ADDR, mreg, `MCUIC_RESP_OKAY);
        chk(wake, |mreg[6:4]);
    endtask

    task automatic pulse(input int b);
        @(posedge i_clk);
        pul[b] <= 1'b1;
        @(posedge i_clk);
        pul[b] <= 1'b0;
        mreg |= eff[b];
    endtask

    // Expected call follows fixed priority over enabled pending flags
    task automatic exp_call();
        int v, k;
        if (mreg[4] && mreg[1]) begin
            v = `MCUIC_VEC_EXT;
            k = `MCUIC_BIT_EXT_FLAG;
        end else if (mreg[5] && mreg[2]) begin
            v = `MCUIC_VEC_T0;
            k = `MCUIC_BIT_T0_FLAG;
        end else begin
            v = `MCUIC_VEC_T1;
            k = `MCUIC_BIT_T1_FLAG;
        end
        repeat (40) if (calls.size() == 0) @(posedge i_clk);
        chk(calls.size(), 1);
        if (calls.size() > 0) chk(calls.pop_front(), {1'b1, v[11:0]});
        mreg &= ~((1 << k) | 1);
    endtask

    task automatic no_call();
        repeat (24) @(posedge i_clk);
        chk(calls.size(), 0);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        look();
        rd(8'h30, 32'h0, `MCUIC_RESP_DECERR);
        wr(8'h30, 8'h0e, `MCUIC_RESP_DECERR);
        look();
        repeat (6) begin
            seed = xs(seed);
            wr(`MCUIC_IRQ_REG_ADDR, seed[7:0] & 8'h8e, `MCUIC_RESP_OKAY);
            look();
        end
        wr(`MCUIC_IRQ_REG_ADDR, 8'h0e, `MCUIC_RESP_OKAY);
        pulse(0);
        no_call();
        look();
        wr(`MCUIC_IRQ_REG_ADDR, 8'h2f, `MCUIC_RESP_OKAY);
        exp_call();
        look();
        pulse(3);
        look();
        // Three sources pending together, pin left low afterwards
        @(posedge i_clk);
        pin_n <= 1'b0;
        mreg |= 32'h10;
        pulse(0);
        pulse(1);
        repeat (6) @(posedge i_clk);
        look();
        wr(`MCUIC_IRQ_REG_ADDR, 8'h7f, `MCUIC_RESP_OKAY);
        exp_call();
        look();
        pulse(2);
        exp_call();
        look();
        wr(`MCUIC_IRQ_REG_ADDR, 8'h4f, `MCUIC_RESP_OKAY);
        exp_call();
        look();
        pin_n <= 1'b1;
        // Core fills the stack to four levels
        pulse(4);
        pulse(4);
        pulse(1);
        wr(`MCUIC_IRQ_REG_ADDR, 8'h4f, `MCUIC_RESP_OKAY);
        no_call();
        look();
        pulse(2);
        exp_call();
        look();
        pulse(3);
        wr(`MCUIC_IRQ_REG_ADDR, 8'h0b, `MCUIC_RESP_OKAY);
        pulse(0);
        no_call();
        look();
        wr(`MCUIC_IRQ_REG_ADDR, 8'h0a, `MCUIC_RESP_OKAY);
        look();
        // Software clear and timer 0 set meet at the write's commit edge
        fork
            wr(`MCUIC_IRQ_REG_ADDR, 8'h0a, `MCUIC_RESP_OKAY);
            begin
                @(posedge i_clk);
                pulse(0);
            end
        join
        mreg |= 32'h20;
        look();
        tally_and_finish();
    end

    // A hang in any handshake ends here
    initial begin
        #200us;
        bad_count++;
        tally_and_finish();
    end
endmodule
